//--- shared/orl_regs_pkg.sv
// register map, field positions, reset values and link constants for the
// overrange / serial link control register bank; used by every rtl file.
// Function
// - one clear bit per virtual converter; 1 clears its overrange flag
// - read-only status byte, one overrange-occurred bit per virtual converter
// - swap bit 0 clear keeps converter order, set exchanges both channels
// - lanes equal two to bits 7:6, converters two to bits 5:3; reset 0x88
// - tail bit pseudo-noise fill when tail control set, none when clear
// - frame alignment characters inserted when control bit 0, suppressed when 1
package orl_regs_pkg;

	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_OVR_CLEAR   = 12'h562;
	localparam logic [11:0] IDX_OVR_STATUS  = 12'h563;
	localparam logic [11:0] IDX_ORDER_SEL   = 12'h564;
	localparam logic [11:0] IDX_RATE_RANGE  = 12'h56E;
	localparam logic [11:0] IDX_PLL_LOCK    = 12'h56F;
	localparam logic [11:0] IDX_QUICK_SETUP = 12'h570;
	localparam logic [11:0] IDX_LINK_CTRL_A = 12'h571;
	localparam logic [11:0] IDX_LINK_CTRL_B = 12'h572;
	localparam logic [11:0] IDX_IRQ_STATUS  = 12'h5F0;
	localparam logic [11:0] IDX_IRQ_MASK    = 12'h5F1;

	// reset values
	localparam logic [7:0] RST_OVR_CLEAR   = 8'h00;
	localparam logic [7:0] RST_ORDER_SEL   = 8'h00;
	localparam logic [7:0] RST_RATE_RANGE  = 8'h10;
	localparam logic [7:0] RST_QUICK_SETUP = 8'h88;
	localparam logic [7:0] RST_LINK_CTRL_A = 8'h14;
	localparam logic [7:0] RST_LINK_CTRL_B = 8'h00;
	localparam logic [2:0] RST_IRQ_MASK    = 3'h0;

	// writable bit masks
	localparam logic [7:0] WMASK_ORDER_SEL  = 8'h01;
	localparam logic [7:0] WMASK_RATE_RANGE = 8'h10;
	localparam logic [7:0] WMASK_LINK_CTRL_B = 8'hF6;

	// field positions
	localparam int POS_SWAP        = 0;
	localparam int POS_LOW_RATE    = 4;
	localparam int POS_PLL_LOCK    = 7;
	localparam int POS_LANES_LO    = 6;
	localparam int POS_CONV_LO     = 3;
	localparam int POS_LINK_PDN    = 0;
	localparam int POS_FRAME_ALIGN_CHAR_INSERT_OFF    = 1;
	localparam int POS_ILAS_LO     = 2;
	localparam int POS_LANE_SYNC   = 4;
	localparam int POS_LONG_TEST   = 5;
	localparam int POS_TAIL_PN     = 6;
	localparam int POS_STANDBY_CGS = 7;

	// interrupt status bits
	localparam int IRQ_OVERRANGE = 0;
	localparam int IRQ_LOCK_LOST = 1;
	localparam int IRQ_LOCK_GOT  = 2;
	localparam int IRQ_BITS      = 3;

	// link control characters
	localparam logic [7:0] CHAR_K28_7 = 8'hFC; // frame end alignment
	localparam logic [7:0] CHAR_K28_3 = 8'h7C; // multiframe end alignment
	localparam logic [7:0] CHAR_K28_5 = 8'hBC; // code group sync

	// pseudo-noise seed for the tail fill generator
	localparam logic [8:0] PN_SEED = 9'h1FF;

endpackage

//--- rtl/tail_pn_gen.sv
// nine-bit pseudo-noise generator (x^9 + x^5 + 1) feeding tail bit fill.
// assumes one shared clock and an asynchronous active low reset.
`timescale 1ns/1ps
module tail_pn_gen #(
	parameter int OUT_BITS = 2
) (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                nrst,
	// control
	input  wire logic                advance,
	// pattern
	output logic      [OUT_BITS-1:0] pnBits
);

	logic [8:0] lfsr_ff;
	logic [8:0] nxt_lfsr;
	integer     i;

	// step the register OUT_BITS times per advance
	always_comb
	begin
		nxt_lfsr = lfsr_ff;
		for (i = 0; i < OUT_BITS; i = i + 1)
		begin
			nxt_lfsr = {nxt_lfsr[7:0], nxt_lfsr[8] ^ nxt_lfsr[4]};
		end
	end

	// hold the sequence between samples
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			lfsr_ff <= orl_regs_pkg::PN_SEED;
		else if (advance)
			lfsr_ff <= nxt_lfsr;
	end

	assign pnBits = lfsr_ff[OUT_BITS-1:0];

endmodule

//--- rtl/overrange_and_serial_link_control_regs.sv
// register bank for the overrange flags and serial link control, with the
// sample formatting and lane alignment character logic that it steers.
// assumes an apb master on ref_clk and sample/lane inputs synchronous to it.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module overrange_and_serial_link_control_regs #(
	parameter int SAMPLE_WIDTH = 16, // transmitted sample width
	parameter int RESOLUTION   = 14, // converter resolution
	parameter int CTRL_BITS    = 0   // control bits per sample
) (
	// clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    nrst,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [15:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic                         pready,
	output logic [31:0]                  prdata,
	output logic                         pslverr,
	// interrupt
	output logic                         irq,
	// converter side
	input  wire logic [7:0]              overrangeEvent,
	input  wire logic                    sampleValid,
	input  wire logic [RESOLUTION-1:0]   sampleA,
	input  wire logic [RESOLUTION-1:0]   sampleB,
	input  wire logic [CTRL_BITS:0]      ctrlA,
	input  wire logic [CTRL_BITS:0]      ctrlB,
	input  wire logic                    pllLocked,
	// formatted samples
	output logic                         wordValid_ff,
	output logic [SAMPLE_WIDTH-1:0]      wordA_ff,
	output logic [SAMPLE_WIDTH-1:0]      wordB_ff,
	// lane octet stream
	input  wire logic                    octetValid,
	input  wire logic [7:0]              octetIn,
	input  wire logic                    frameEnd,
	input  wire logic                    multiframeEnd,
	output logic                         octetValid_ff,
	output logic [7:0]                   octetOut_ff,
	output logic                         octetIsK_ff,
	// link configuration
	output logic [3:0]                   laneCount,
	output logic [7:0]                   converterCount,
	output logic                         lowRateRange,
	output logic                         linkPowerDown,
	output logic [1:0]                   ilasMode,
	output logic                         laneSyncEnable,
	output logic                         longTestEnable,
	output logic                         standbyCgs,
	output logic [1:0]                   syncPinMode,
	output logic                         syncActiveHigh,
	output logic                         syncCmos,
	output logic                         codeBypass,
	output logic                         codeInvert
);

	localparam int TAIL_BITS = SAMPLE_WIDTH - RESOLUTION - CTRL_BITS;

	logic [7:0]           ovrClear_ff;
	logic [7:0]           ovrStatus_ff;
	logic [7:0]           orderSel_ff;
	logic [7:0]           rateRange_ff;
	logic [7:0]           quickSetup_ff;
	logic [7:0]           linkCtrlA_ff;
	logic [7:0]           linkCtrlB_ff;
	logic [2:0]           irqStatus_ff;
	logic [2:0]           irqMask_ff;
	logic                 lockPrev_ff;
	logic [7:0]           lastFrameOctet_ff;
	logic [11:0]          regIdx;
	logic                 addrOk;
	logic                 wrEn;
	logic                 rdEn;
	logic [7:0]           nxt_ovrStatus;
	logic [2:0]           irqEvent;
	logic [7:0]           wbyte;
	logic [TAIL_BITS-1:0] pnBits;
	logic [TAIL_BITS-1:0] tailBits;
	logic [RESOLUTION-1:0] firstSample;
	logic [RESOLUTION-1:0] secondSample;
	logic [CTRL_BITS:0]   firstCtrl;
	logic [CTRL_BITS:0]   secondCtrl;
	logic [SAMPLE_WIDTH-1:0] nxt_wordA;
	logic [SAMPLE_WIDTH-1:0] nxt_wordB;

	// apb decode: zero wait states, word aligned, unmapped gives pslverr
	assign regIdx = paddr[13:2];
	assign wbyte  = pwdata[7:0];
	always_comb
	begin
		addrOk = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0);
		case (regIdx)
			orl_regs_pkg::IDX_OVR_CLEAR,
			orl_regs_pkg::IDX_OVR_STATUS,
			orl_regs_pkg::IDX_ORDER_SEL,
			orl_regs_pkg::IDX_RATE_RANGE,
			orl_regs_pkg::IDX_PLL_LOCK,
			orl_regs_pkg::IDX_QUICK_SETUP,
			orl_regs_pkg::IDX_LINK_CTRL_A,
			orl_regs_pkg::IDX_LINK_CTRL_B,
			orl_regs_pkg::IDX_IRQ_STATUS,
			orl_regs_pkg::IDX_IRQ_MASK: addrOk = addrOk;
			default: addrOk = 1'b0;
		endcase
	end
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addrOk;
	assign wrEn    = psel && penable && pwrite && addrOk;
	assign rdEn    = psel && penable && !pwrite && addrOk;

	// read data register, updated on each read access
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
		begin
			case (addrOk ? regIdx : 12'h000) // refused accesses read zero
				orl_regs_pkg::IDX_OVR_CLEAR:   prdata <= {24'h000000, ovrClear_ff};
				orl_regs_pkg::IDX_OVR_STATUS:  prdata <= {24'h000000, ovrStatus_ff};
				orl_regs_pkg::IDX_ORDER_SEL:   prdata <= {24'h000000, orderSel_ff};
				orl_regs_pkg::IDX_RATE_RANGE:  prdata <= {24'h000000, rateRange_ff};
				orl_regs_pkg::IDX_PLL_LOCK:    prdata <= {24'h000000, pllLocked, 7'h00};
				orl_regs_pkg::IDX_QUICK_SETUP: prdata <= {24'h000000, quickSetup_ff};
				orl_regs_pkg::IDX_LINK_CTRL_A: prdata <= {24'h000000, linkCtrlA_ff};
				orl_regs_pkg::IDX_LINK_CTRL_B: prdata <= {24'h000000, linkCtrlB_ff};
				orl_regs_pkg::IDX_IRQ_STATUS:  prdata <= {29'h0, irqStatus_ff};
				orl_regs_pkg::IDX_IRQ_MASK:    prdata <= {29'h0, irqMask_ff};
				default:                       prdata <= 32'h0000_0000;
			endcase
		end
	end

	// plain read/write configuration registers
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ovrClear_ff   <= orl_regs_pkg::RST_OVR_CLEAR;
			orderSel_ff   <= orl_regs_pkg::RST_ORDER_SEL;
			rateRange_ff  <= orl_regs_pkg::RST_RATE_RANGE;
			quickSetup_ff <= orl_regs_pkg::RST_QUICK_SETUP;
			linkCtrlA_ff  <= orl_regs_pkg::RST_LINK_CTRL_A;
			linkCtrlB_ff  <= orl_regs_pkg::RST_LINK_CTRL_B;
			irqMask_ff    <= orl_regs_pkg::RST_IRQ_MASK;
		end
		else if (wrEn)
		begin
			case (regIdx)
				orl_regs_pkg::IDX_OVR_CLEAR:   ovrClear_ff   <= wbyte;
				orl_regs_pkg::IDX_ORDER_SEL:
					orderSel_ff <= wbyte & orl_regs_pkg::WMASK_ORDER_SEL;
				orl_regs_pkg::IDX_RATE_RANGE:
					rateRange_ff <= wbyte & orl_regs_pkg::WMASK_RATE_RANGE;
				orl_regs_pkg::IDX_QUICK_SETUP: quickSetup_ff <= wbyte;
				orl_regs_pkg::IDX_LINK_CTRL_A: linkCtrlA_ff  <= wbyte;
				orl_regs_pkg::IDX_LINK_CTRL_B:
					linkCtrlB_ff <= wbyte & orl_regs_pkg::WMASK_LINK_CTRL_B;
				orl_regs_pkg::IDX_IRQ_MASK:    irqMask_ff    <= wbyte[2:0];
				default:                       irqMask_ff    <= irqMask_ff;
			endcase
		end
	end

	// sticky overrange flags; a clear bit at 1 empties and holds its flag
	always_comb
	begin
		nxt_ovrStatus = (ovrStatus_ff | overrangeEvent) & ~ovrClear_ff;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			ovrStatus_ff <= 8'h00;
		else
			ovrStatus_ff <= nxt_ovrStatus;
	end

	// interrupt events: new overrange, lock lost, lock gained
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			lockPrev_ff <= 1'b0;
		else
			lockPrev_ff <= pllLocked;
	end
	assign irqEvent[orl_regs_pkg::IRQ_OVERRANGE] = |(nxt_ovrStatus & ~ovrStatus_ff);
	assign irqEvent[orl_regs_pkg::IRQ_LOCK_LOST] = lockPrev_ff && !pllLocked;
	assign irqEvent[orl_regs_pkg::IRQ_LOCK_GOT]  = !lockPrev_ff && pllLocked;

	// write one to clear; an event in the same cycle wins
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			irqStatus_ff <= 3'h0;
		else if (wrEn && regIdx == orl_regs_pkg::IDX_IRQ_STATUS)
			irqStatus_ff <= (irqStatus_ff & ~wbyte[2:0]) | irqEvent;
		else
			irqStatus_ff <= irqStatus_ff | irqEvent;
	end
	assign irq = |(irqStatus_ff & irqMask_ff);

	// link shape and mode fields decoded for the transmitter
	assign laneCount      = 4'h1 << quickSetup_ff[orl_regs_pkg::POS_LANES_LO +: 2];
	assign converterCount = 8'h01 << quickSetup_ff[orl_regs_pkg::POS_CONV_LO +: 3];
	assign lowRateRange   = rateRange_ff[orl_regs_pkg::POS_LOW_RATE];
	assign linkPowerDown  = linkCtrlA_ff[orl_regs_pkg::POS_LINK_PDN];
	assign ilasMode       = linkCtrlA_ff[orl_regs_pkg::POS_ILAS_LO +: 2];
	assign laneSyncEnable = linkCtrlA_ff[orl_regs_pkg::POS_LANE_SYNC];
	assign longTestEnable = linkCtrlA_ff[orl_regs_pkg::POS_LONG_TEST];
	assign standbyCgs     = linkCtrlA_ff[orl_regs_pkg::POS_STANDBY_CGS];
	assign syncPinMode    = linkCtrlB_ff[7:6];
	assign syncActiveHigh = linkCtrlB_ff[5];
	assign syncCmos       = linkCtrlB_ff[4];
	assign codeBypass     = linkCtrlB_ff[2];
	assign codeInvert     = linkCtrlB_ff[1];

	// tail bit pattern source, TAIL_BITS steps per sample pair
	tail_pn_gen #(
		.OUT_BITS (TAIL_BITS)
	) tail_pn_gen_i (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.advance (sampleValid),
		.pnBits  (pnBits)
	);

	// tail bits carry noise only when enabled, else zero
	assign tailBits = linkCtrlA_ff[orl_regs_pkg::POS_TAIL_PN] ? pnBits
		: {TAIL_BITS{1'b0}};

	// converter order: swap exchanges the two output positions
	always_comb
	begin
		if (orderSel_ff[orl_regs_pkg::POS_SWAP])
		begin
			firstSample  = sampleB;
			secondSample = sampleA;
			firstCtrl    = ctrlB;
			secondCtrl   = ctrlA;
		end
		else
		begin
			firstSample  = sampleA;
			secondSample = sampleB;
			firstCtrl    = ctrlA;
			secondCtrl   = ctrlB;
		end
	end

	// pack sample, control bits and tail bits; no control field when none are carried
	if (CTRL_BITS > 0)
	begin : g_ctrl
		assign nxt_wordA = {firstSample, firstCtrl[CTRL_BITS:1], tailBits};
		assign nxt_wordB = {secondSample, secondCtrl[CTRL_BITS:1], tailBits};
	end
	else
	begin : g_no_ctrl
		assign nxt_wordA = {firstSample, tailBits};
		assign nxt_wordB = {secondSample, tailBits};
	end

	// assemble the transmitted words: sample, control bits, tail bits
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wordValid_ff <= 1'b0;
			wordA_ff     <= '0;
			wordB_ff     <= '0;
		end
		else
		begin
			wordValid_ff <= sampleValid && !linkPowerDown;
			if (sampleValid)
			begin
				wordA_ff <= nxt_wordA;
				wordB_ff <= nxt_wordB;
			end
		end
	end

	// remember the last octet of each frame for repeat detection
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			lastFrameOctet_ff <= 8'h00;
		else if (octetValid && frameEnd)
			lastFrameOctet_ff <= octetIn;
	end

	// alignment character insertion on a repeated frame end octet
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			octetValid_ff <= 1'b0;
			octetOut_ff   <= 8'h00;
			octetIsK_ff   <= 1'b0;
		end
		else
		begin
			octetValid_ff <= octetValid && !linkPowerDown;
			octetOut_ff   <= octetIn;
			octetIsK_ff   <= 1'b0;
			if (octetValid && frameEnd && octetIn == lastFrameOctet_ff
				&& !linkCtrlA_ff[orl_regs_pkg::POS_FRAME_ALIGN_CHAR_INSERT_OFF])
			begin
				octetIsK_ff <= 1'b1;
				if (laneSyncEnable && multiframeEnd)
					octetOut_ff <= orl_regs_pkg::CHAR_K28_3;
				else
					octetOut_ff <= orl_regs_pkg::CHAR_K28_7;
			end
		end
	end

endmodule

//--- verification/orl_properties.sv
// port checks for the overrange / serial link register bank.
// assumes a bind from the bench and the single ref_clk domain.
`timescale 1ns/1ps
module orl_properties #(
	parameter int SAMPLE_WIDTH = 16,
	parameter int RESOLUTION   = 14,
	parameter int CTRL_BITS    = 0
) (
	// clock, reset and apb
	input wire logic                    ref_clk,
	input wire logic                    nrst,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic [15:0]             paddr,
	input wire logic                    pslverr,
	// samples
	input wire logic                    sampleValid,
	input wire logic [RESOLUTION-1:0]   sampleA,
	input wire logic [RESOLUTION-1:0]   sampleB,
	input wire logic                    linkPowerDown,
	input wire logic                    wordValid_ff,
	input wire logic [SAMPLE_WIDTH-1:0] wordA_ff,
	input wire logic [SAMPLE_WIDTH-1:0] wordB_ff,
	// octets and link shape
	input wire logic                    octetValid,
	input wire logic [7:0]              octetIn,
	input wire logic                    frameEnd,
	input wire logic                    multiframeEnd,
	input wire logic                    octetValid_ff,
	input wire logic [7:0]              octetOut_ff,
	input wire logic                    octetIsK_ff,
	input wire logic                    laneSyncEnable,
	input wire logic [3:0]              laneCount,
	input wire logic [7:0]              converterCount
);
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// sample fields of the two word slots
	logic [RESOLUTION-1:0] hiA;
	logic [RESOLUTION-1:0] hiB;
	assign hiA = wordA_ff[SAMPLE_WIDTH-1 -: RESOLUTION];
	assign hiB = wordB_ff[SAMPLE_WIDTH-1 -: RESOLUTION];

	word_latency_a: assert property (sampleValid && !linkPowerDown |=> wordValid_ff)
		else $error("word late");
	word_quiet_a: assert property (!sampleValid |=> !wordValid_ff)
		else $error("word without sample");
	word_order_a: assert property (wordValid_ff |->
		(hiA == $past(sampleA) && hiB == $past(sampleB)) ||
		(hiA == $past(sampleB) && hiB == $past(sampleA)))
		else $error("word slots wrong");
	lane_shape_a: assert property ($onehot(laneCount) && $onehot(converterCount))
		else $error("counts not powers of two");
	k_cause_a: assert property (octetIsK_ff |-> $past(octetValid && frameEnd))
		else $error("control char without frame end");
	k_char_a: assert property (octetIsK_ff |-> octetOut_ff == 8'hFC ||
		(octetOut_ff == 8'h7C && $past(multiframeEnd) && laneSyncEnable))
		else $error("wrong control char");
	octet_pass_a: assert property (octetValid_ff && !octetIsK_ff |-> octetOut_ff == $past(octetIn))
		else $error("octet altered");
	octet_delay_a: assert property (octetValid && !linkPowerDown |=> octetValid_ff)
		else $error("octet late");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	misalign_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access accepted");
endmodule

//--- verification/lane_receiver_model.sv
// far-end lane receiver: counts alignment characters in the octet stream.
// assumes the bank's clock and reset.
`timescale 1ns/1ps
module lane_receiver_model (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	// lane octets
	input  wire logic       octetValid_ff,
	input  wire logic [7:0] octetOut_ff,
	input  wire logic       octetIsK_ff,
	// alignment characters seen
	output logic      [7:0] alignSeen
);
	// count frame and multiframe end characters
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			alignSeen <= 8'h00;
		else if (octetValid_ff && octetIsK_ff && (octetOut_ff == orl_regs_pkg::CHAR_K28_7 ||
			octetOut_ff == orl_regs_pkg::CHAR_K28_3))
			alignSeen <= alignSeen + 8'h01;
	end
endmodule

//--- verification/tb.sv
// self-checking bench for the overrange / serial link register bank.
// assumes the package, design, checker and receiver model are compiled first.
`timescale 1ns/1ps
module tb;
	// design inputs
	logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] overrangeEvent = 8'h00, octetIn = 8'h00;
	logic sampleValid = 1'b0, pllLocked = 1'b0, octetValid = 1'b0;
	logic frameEnd = 1'b0, multiframeEnd = 1'b0;
	logic [13:0] sampleA = 14'h0, sampleB = 14'h0;
	// design outputs
	logic pready, pslverr, irq, wordValid_ff, octetValid_ff, octetIsK_ff;
	logic [31:0] prdata;
	logic [15:0] wordA_ff, wordB_ff;
	logic [7:0] octetOut_ff, converterCount, alignSeen, rq;
	logic [3:0] laneCount;
	logic [1:0] tails;
	logic re;
	logic lowRateRange, linkPowerDown, laneSyncEnable, longTestEnable, standbyCgs;
	logic syncActiveHigh, syncCmos, codeBypass, codeInvert;
	logic [1:0] ilasMode, syncPinMode;
	int num_errors = 0, checked = 0, cyc = 0;

	overrange_and_serial_link_control_regs overrange_and_serial_link_control_regs_i (
		.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.irq(irq), .overrangeEvent(overrangeEvent), .sampleValid(sampleValid),
		.sampleA(sampleA), .sampleB(sampleB), .ctrlA(1'b0), .ctrlB(1'b0),
		.pllLocked(pllLocked), .wordValid_ff(wordValid_ff), .wordA_ff(wordA_ff),
		.wordB_ff(wordB_ff), .octetValid(octetValid), .octetIn(octetIn), .frameEnd(frameEnd),
		.multiframeEnd(multiframeEnd), .octetValid_ff(octetValid_ff),
		.octetOut_ff(octetOut_ff), .octetIsK_ff(octetIsK_ff), .laneCount(laneCount),
		.converterCount(converterCount), .lowRateRange(lowRateRange),
		.linkPowerDown(linkPowerDown), .ilasMode(ilasMode), .laneSyncEnable(laneSyncEnable),
		.longTestEnable(longTestEnable), .standbyCgs(standbyCgs), .syncPinMode(syncPinMode),
		.syncActiveHigh(syncActiveHigh), .syncCmos(syncCmos), .codeBypass(codeBypass),
		.codeInvert(codeInvert));
	lane_receiver_model lane_receiver_model_i (.ref_clk(ref_clk), .nrst(nrst),
		.octetValid_ff(octetValid_ff), .octetOut_ff(octetOut_ff), .octetIsK_ff(octetIsK_ff),
		.alignSeen(alignSeen));

	// clock and hang guard
	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			results();
		end
	end

	// compare and report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checked %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// one apb transfer; register index becomes byte address
	task automatic xfer(input logic w, input logic [11:0] ix, input logic [7:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, ix, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		// wait for the answer; ends once pready is high, else the bench timeout ends it
		do
		begin
			@(posedge ref_clk);
		end
		while (pready !== 1'b1);
		rq = prdata[7:0];
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] ix, input logic [7:0] d);
		xfer(1'b1, ix, d);
	endtask
	task automatic rd(input logic [11:0] ix, input logic [7:0] ex);
		xfer(1'b0, ix, 8'h00);
		chk({24'h0, rq}, {24'h0, ex});
	endtask

	// one overrange pulse
	task automatic ev(input logic [7:0] v);
		overrangeEvent <= v;
		@(posedge ref_clk);
		overrangeEvent <= 8'h00;
	endtask
	// one sample pair; sample field sits above the two tail bits
	task automatic smp(input logic [13:0] a, input logic [13:0] b, input logic sw);
		sampleA <= a;
		sampleB <= b;
		sampleValid <= 1'b1;
		@(posedge ref_clk);
		sampleValid <= 1'b0;
		#1 chk({wordA_ff[15:2], wordB_ff[15:2]}, sw ? {4'h0, b, a} : {4'h0, a, b});
		tails = tails | wordA_ff[1:0] | wordB_ff[1:0];
	endtask
	// one octet of 0x33; ex is control flag and value seen next cycle
	task automatic oct(input logic fe, input logic mf, input logic [8:0] ex);
		octetValid <= 1'b1;
		octetIn <= 8'h33;
		frameEnd <= fe;
		multiframeEnd <= mf;
		@(posedge ref_clk);
		octetValid <= 1'b0;
		#1 chk({23'h0, octetIsK_ff, octetOut_ff}, {23'h0, ex});
	endtask

	localparam logic [11:0] IX [8] = '{12'h562, 12'h563, 12'h564, 12'h56E, 12'h56F, 12'h570,
		12'h571, 12'h572};
	localparam logic [7:0] RV [8] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h88, 8'h14, 8'h00};

	// main sequence
	initial
	begin
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd(IX[i], RV[i]);
		rd(12'h565, 8'h00);
		chk({31'h0, re}, 32'h1);
		chk({24'h0, lowRateRange, linkPowerDown, ilasMode, laneSyncEnable, longTestEnable,
			standbyCgs, 1'b0}, 32'h98);
		wr(12'h563, 8'hFF);
		rd(12'h563, 8'h00);
		wr(12'h564, 8'hFF);
		rd(12'h564, 8'h01);
		wr(12'h572, 8'hFF);
		rd(12'h572, 8'hF6);
		chk({24'h0, syncPinMode, syncActiveHigh, syncCmos, 1'b0, codeBypass, codeInvert,
			1'b0}, 32'hF6);
		pllLocked <= 1'b1;
		rd(12'h56F, 8'h80);
		$display("register test done");
		wr(12'h5F1, 8'h01);
		ev(8'h28);
		#1 chk({31'h0, irq}, 32'h1);
		rd(12'h563, 8'h28);
		repeat (20) @(posedge ref_clk);
		rd(12'h563, 8'h28);
		wr(12'h562, 8'h08);
		ev(8'h08);
		rd(12'h563, 8'h20);
		wr(12'h562, 8'h00);
		wr(12'h5F0, 8'h07);
		#1 chk({31'h0, irq}, 32'h0);
		wr(12'h5F1, 8'h00);
		ev(8'h01);
		rd(12'h563, 8'h21);
		#1 chk({31'h0, irq}, 32'h0);
		$display("overrange test done");
		tails = 2'b00;
		smp(14'h1234, 14'h0ABC, 1'b1);
		wr(12'h564, 8'h00);
		smp(14'h3FFF, 14'h0001, 1'b0);
		chk({30'h0, tails}, 32'h0);
		wr(12'h571, 8'h54);
		for (int i = 0; i < 4; i++)
			smp(14'(i * 97), 14'h2AAA, 1'b0);
		chk({31'h0, tails != 2'b00}, 32'h1);
		$display("sample test done");
		for (int k = 0; k < 4; k++)
		begin
			wr(12'h570, {k[1:0], 3'(7 - k), 3'b000});
			#1 chk({28'h0, laneCount}, 32'(1 << k));
			chk({24'h0, converterCount}, 32'(1 << (7 - k)));
		end
		$display("link shape test done");
		oct(1'b1, 1'b0, 9'h033);
		oct(1'b1, 1'b0, 9'h1FC);
		oct(1'b1, 1'b1, 9'h17C);
		oct(1'b0, 1'b0, 9'h033);
		wr(12'h571, 8'h16);
		oct(1'b1, 1'b0, 9'h033);
		chk({24'h0, alignSeen}, 32'h2);
		$display("octet test done");
		results();
	end
endmodule

bind overrange_and_serial_link_control_regs orl_properties #(.SAMPLE_WIDTH(SAMPLE_WIDTH),
	.RESOLUTION(RESOLUTION), .CTRL_BITS(CTRL_BITS)) orl_properties_i (.ref_clk(ref_clk),
	.nrst(nrst), .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
	.sampleValid(sampleValid), .sampleA(sampleA), .sampleB(sampleB),
	.linkPowerDown(linkPowerDown), .wordValid_ff(wordValid_ff), .wordA_ff(wordA_ff),
	.wordB_ff(wordB_ff), .octetValid(octetValid), .octetIn(octetIn), .frameEnd(frameEnd),
	.multiframeEnd(multiframeEnd), .octetValid_ff(octetValid_ff), .octetOut_ff(octetOut_ff),
	.octetIsK_ff(octetIsK_ff), .laneSyncEnable(laneSyncEnable), .laneCount(laneCount),
	.converterCount(converterCount));
